// File: design/slsc_status_ctrl.v
// Operation
// RULE1: the red, green and blue status outputs are active low, a low lights the segment.
// RULE2: idle in data or framed-data mode shows green, idle in command mode shows orange.
// RULE3: connecting shows purple and connected shows blue in any mode.
// RULE4: while connected the lit segment flashes during data activity and is steady otherwise.
// RULE5: connecting and connected come only from serial-emulation connection state.
// RULE6: switch 2 low with switch 1 high at start-up restores the uart defaults.
// RULE7: switch 2 going low in normal operation requests a connection to a peripheral.
// RULE8: both switches low at start-up enter bootloader mode.
// RULE9: both switches held low for 10 s from start-up leave bootloader and restore factory settings.
// RULE10: dsr is interpreted per configuration as command mode, disconnect, uart enable or sleep.
// RULE11: dtr shows per configuration the mode, an emulation peer, a bonded device or a gap link.
// RULE12: 11 io pins, each input or output by command, inputs with pull-up, pull-down or none.
// RULE13: reset returns all of this logic to its initial state.
// RULE14: the switches are sampled once, synchronised and debounced, after reset release.
// RULE15: status outputs stay high from reset until the first mode is decided.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "slsc_regs.vh"
module slsc_status_ctrl #(
	parameter IO_N = 11,
	parameter [31:0] FACTORY_HOLD_CYC = `SLSC_FACTORY_HOLD_S * `SLSC_CLK_HZ,
	parameter [31:0] FLASH_HALF_CYC = `SLSC_FLASH_HALF_CYC
) (
	// clock and reset
	input wire i_clk,
	input wire i_rstn,
	// register port
	input wire [3:0] i_addr,
	input wire [15:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [15:0] o_rdata,
	// connection state from the emulation service
	input wire i_emu_connecting,
	input wire i_emu_connected,
	input wire i_emu_activity,
	// switches, active low pins
	input wire i_switch1_n,
	input wire i_switch2_n,
	// uart control lines
	input wire i_dsr,
	output reg o_dtr,
	// status led, active low
	output reg o_red_n,
	output reg o_green_n,
	output reg o_blue_n,
	// start-up and control results
	output reg o_bootloader,
	output reg o_uart_defaults,
	output reg o_factory_restore,
	output reg o_connect_req,
	output reg o_dsr_cmd_mode,
	output reg o_dsr_disconnect,
	output reg o_uart_enable,
	output reg o_sleep,
	// io pins
	input wire [IO_N-1:0] i_io,
	output reg [IO_N-1:0] o_io,
	output reg [IO_N-1:0] o_io_oe,
	output reg [IO_N-1:0] o_io_pu,
	output reg [IO_N-1:0] o_io_pd
);

localparam ST_INIT = 4'h1;
localparam ST_DEBOUNCE = 4'h2;
localparam ST_BOOT = 4'h4;
localparam ST_RUN = 4'h8;

reg [3:0] state_reg;
reg [1:0] sw1_sync_reg, sw2_sync_reg, dsr_sync_reg;
reg [IO_N-1:0] io_meta_reg, io_sync_reg;
reg [4:0] deb_cnt_reg;
reg sw1_prev_reg, sw2_prev_reg;
reg [31:0] hold_cnt_reg;
reg [31:0] flash_cnt_reg;
reg flash_phase_reg;
reg sw2_last_reg, dsr_last_reg;
reg [7:0] ctrl_reg;
reg [IO_N-1:0] io_dir_reg, io_out_reg, io_pen_reg, io_pup_reg;
reg [3:0] event_reg;
reg [3:0] ev_set;
reg [2:0] rgb_next;
reg dtr_next;

wire [1:0] mode = ctrl_reg[`SLSC_CTRL_MODE_LSB +: 2];
wire [1:0] dsr_fn = ctrl_reg[`SLSC_CTRL_DSR_FN_LSB +: 2];
wire [1:0] dtr_fn = ctrl_reg[`SLSC_CTRL_DTR_FN_LSB +: 2];
wire sw1 = sw1_sync_reg[1];
wire sw2 = sw2_sync_reg[1];
wire dsr = dsr_sync_reg[1];
wire both_low = !sw1 && !sw2;
wire dsr_rise = dsr && !dsr_last_reg;

// two-stage synchronisers for pins
always @(posedge i_clk) begin
	if (!i_rstn) begin
		sw1_sync_reg <= 2'h3;
		sw2_sync_reg <= 2'h3;
		dsr_sync_reg <= 2'h0;
		io_meta_reg <= {IO_N{1'b0}};
		io_sync_reg <= {IO_N{1'b0}};
	end else begin
		sw1_sync_reg <= {sw1_sync_reg[0], i_switch1_n};
		sw2_sync_reg <= {sw2_sync_reg[0], i_switch2_n};
		dsr_sync_reg <= {dsr_sync_reg[0], i_dsr};
		io_meta_reg <= i_io;
		io_sync_reg <= io_meta_reg;
	end
end

// start-up sequencer
always @(posedge i_clk) begin
	if (!i_rstn) begin //RULE13
		state_reg <= ST_INIT;
		deb_cnt_reg <= 5'h00;
		sw1_prev_reg <= 1'b1;
		sw2_prev_reg <= 1'b1;
		hold_cnt_reg <= 32'h0;
		o_bootloader <= 1'b0;
		o_uart_defaults <= 1'b0;
		o_factory_restore <= 1'b0;
	end else begin
		o_uart_defaults <= 1'b0;
		o_factory_restore <= 1'b0;
		case (state_reg)
			ST_INIT: begin
				// one cycle only: take the synchronised switch levels as the first debounce reference
				deb_cnt_reg <= 5'h00;
				sw1_prev_reg <= sw1;
				sw2_prev_reg <= sw2;
				state_reg <= ST_DEBOUNCE;
			end
			ST_DEBOUNCE: begin
				if (sw1 != sw1_prev_reg || sw2 != sw2_prev_reg) begin //RULE14
					deb_cnt_reg <= 5'h00;
					sw1_prev_reg <= sw1;
					sw2_prev_reg <= sw2;
				end else if (deb_cnt_reg == `SLSC_DEBOUNCE_CYC - 1) begin
					if (!sw1_prev_reg && !sw2_prev_reg) begin
						o_bootloader <= 1'b1; //RULE8
						hold_cnt_reg <= 32'h0;
						state_reg <= ST_BOOT;
					end else begin
						o_uart_defaults <= sw1_prev_reg && !sw2_prev_reg; //RULE6
						state_reg <= ST_RUN;
					end
				end else begin
					deb_cnt_reg <= deb_cnt_reg + 5'h01;
				end
			end
			ST_BOOT: begin
				// release of either switch ends the hold; bootloader stays
				if (!both_low) begin
					hold_cnt_reg <= FACTORY_HOLD_CYC;
				end else if (hold_cnt_reg < FACTORY_HOLD_CYC - 1) begin
					hold_cnt_reg <= hold_cnt_reg + 32'h1;
				end else if (hold_cnt_reg == FACTORY_HOLD_CYC - 1) begin
					o_bootloader <= 1'b0; //RULE9
					o_factory_restore <= 1'b1;
					hold_cnt_reg <= FACTORY_HOLD_CYC;
					state_reg <= ST_RUN;
				end
			end
			ST_RUN: begin
			end
			default: state_reg <= ST_INIT;
		endcase
	end
end

// flash timer, runs only while activity is seen on a connection
always @(posedge i_clk) begin
	if (!i_rstn) begin
		flash_cnt_reg <= 32'h0;
		flash_phase_reg <= 1'b0;
	end else if (i_emu_connected && i_emu_activity) begin //RULE4
		if (flash_cnt_reg >= FLASH_HALF_CYC - 1) begin
			flash_cnt_reg <= 32'h0;
			flash_phase_reg <= !flash_phase_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 32'h1;
		end
	end else begin
		flash_cnt_reg <= 32'h0;
		flash_phase_reg <= 1'b0;
	end
end

// colour select: {red_n, green_n, blue_n}
always @* begin
	if (state_reg != ST_RUN) begin
		rgb_next = 3'h7; //RULE15
	end else if (i_emu_connected) begin //RULE5
		rgb_next = (flash_phase_reg && i_emu_activity) ? 3'h7 : 3'h6; //RULE3 RULE4
	end else if (i_emu_connecting) begin
		rgb_next = 3'h2; //RULE3
	end else if (mode == `SLSC_MODE_CMD) begin
		rgb_next = 3'h1; //RULE2
	end else begin
		rgb_next = 3'h5; //RULE2
	end
end

always @* begin
	case (dtr_fn) //RULE11
		`SLSC_DTR_MODE: dtr_next = (mode != `SLSC_MODE_CMD);
		`SLSC_DTR_PEER: dtr_next = i_emu_connected;
		`SLSC_DTR_BONDED: dtr_next = ctrl_reg[`SLSC_CTRL_BONDED_BIT];
		default: dtr_next = ctrl_reg[`SLSC_CTRL_GAP_BIT];
	endcase
end

always @* begin
	ev_set = 4'h0;
	ev_set[`SLSC_EV_UART_DEFAULTS] = o_uart_defaults;
	ev_set[`SLSC_EV_CONNECT_REQ] = (state_reg == ST_RUN) && sw2_last_reg && !sw2;
	ev_set[`SLSC_EV_FACTORY] = o_factory_restore;
	ev_set[`SLSC_EV_DSR] = dsr_rise;
end

// led, dtr, dsr actions and connect requests
always @(posedge i_clk) begin
	if (!i_rstn) begin
		o_red_n <= 1'b1; //RULE1
		o_green_n <= 1'b1;
		o_blue_n <= 1'b1;
		o_dtr <= 1'b0;
		sw2_last_reg <= 1'b1;
		dsr_last_reg <= 1'b0;
		o_connect_req <= 1'b0;
		o_dsr_cmd_mode <= 1'b0;
		o_dsr_disconnect <= 1'b0;
		o_uart_enable <= 1'b1;
		o_sleep <= 1'b0;
	end else begin
		{o_red_n, o_green_n, o_blue_n} <= rgb_next; //RULE1
		o_dtr <= dtr_next;
		sw2_last_reg <= sw2;
		dsr_last_reg <= dsr;
		o_connect_req <= ev_set[`SLSC_EV_CONNECT_REQ]; //RULE7
		o_dsr_cmd_mode <= dsr_rise && dsr_fn == `SLSC_DSR_CMD; //RULE10
		o_dsr_disconnect <= dsr_rise && dsr_fn == `SLSC_DSR_DISC; //RULE10
		o_uart_enable <= (dsr_fn == `SLSC_DSR_UART_EN) ? dsr : 1'b1; //RULE10
		// level controlled: dsr high puts the device to sleep, low wakes it
		o_sleep <= (dsr_fn == `SLSC_DSR_SLEEP) && dsr; //RULE10
	end
end

// register file
always @(posedge i_clk) begin
	if (!i_rstn) begin
		ctrl_reg <= `SLSC_CTRL_RESET;
		io_dir_reg <= {IO_N{1'b0}};
		io_out_reg <= {IO_N{1'b0}};
		io_pen_reg <= {IO_N{1'b0}};
		io_pup_reg <= {IO_N{1'b0}};
		event_reg <= 4'h0;
		o_rdata <= 16'h0000;
	end else begin
		// a new event wins over a clear in the same cycle
		if (i_wr && i_addr == `SLSC_ADDR_EVENT) begin
			event_reg <= (event_reg & ~i_wdata[3:0]) | ev_set;
		end else begin
			event_reg <= event_reg | ev_set;
		end
		if (i_wr) begin
			case (i_addr)
				`SLSC_ADDR_CTRL: ctrl_reg <= i_wdata[7:0];
				`SLSC_ADDR_IO_DIR: io_dir_reg <= i_wdata[IO_N-1:0]; //RULE12
				`SLSC_ADDR_IO_OUT: io_out_reg <= i_wdata[IO_N-1:0];
				`SLSC_ADDR_IO_PULL_EN: io_pen_reg <= i_wdata[IO_N-1:0]; //RULE12
				`SLSC_ADDR_IO_PULL_UP: io_pup_reg <= i_wdata[IO_N-1:0];
				default: ;
			endcase
		end
		o_rdata <= 16'h0000;
		if (i_rd) begin
			case (i_addr)
				`SLSC_ADDR_CTRL: o_rdata <= {8'h00, ctrl_reg};
				`SLSC_ADDR_STATUS: o_rdata <= {8'h00, state_reg, o_bootloader, i_emu_connected,
					i_emu_connecting, o_dtr};
				`SLSC_ADDR_IO_DIR: o_rdata[IO_N-1:0] <= io_dir_reg;
				`SLSC_ADDR_IO_OUT: o_rdata[IO_N-1:0] <= io_out_reg;
				`SLSC_ADDR_IO_PULL_EN: o_rdata[IO_N-1:0] <= io_pen_reg;
				`SLSC_ADDR_IO_PULL_UP: o_rdata[IO_N-1:0] <= io_pup_reg;
				`SLSC_ADDR_IO_IN: o_rdata[IO_N-1:0] <= io_sync_reg;
				`SLSC_ADDR_EVENT: o_rdata <= {12'h000, event_reg};
				default: o_rdata <= 16'h0000;
			endcase
		end
	end
end

// per-pin drive and pulls; pulls only act on inputs
genvar gi;
generate
	for (gi = 0; gi < IO_N; gi = gi + 1) begin : g_io
		always @(posedge i_clk) begin
			if (!i_rstn) begin
				o_io[gi] <= 1'b0;
				o_io_oe[gi] <= 1'b0;
				o_io_pu[gi] <= 1'b0;
				o_io_pd[gi] <= 1'b0;
			end else begin
				o_io[gi] <= io_out_reg[gi]; //RULE12
				o_io_oe[gi] <= io_dir_reg[gi];
				o_io_pu[gi] <= !io_dir_reg[gi] && io_pen_reg[gi] && io_pup_reg[gi];
				o_io_pd[gi] <= !io_dir_reg[gi] && io_pen_reg[gi] && !io_pup_reg[gi];
			end
		end
	end
endgenerate

endmodule // slsc_status_ctrl

// File: design/slsc_regs.vh
`ifndef SLSC_REGS_VH
`define SLSC_REGS_VH
// register offsets (plain port, 4-bit address)
`define SLSC_ADDR_CTRL 4'h0
`define SLSC_ADDR_STATUS 4'h1
`define SLSC_ADDR_IO_DIR 4'h2
`define SLSC_ADDR_IO_OUT 4'h3
`define SLSC_ADDR_IO_PULL_EN 4'h4
`define SLSC_ADDR_IO_PULL_UP 4'h5
`define SLSC_ADDR_IO_IN 4'h6
`define SLSC_ADDR_EVENT 4'h7
// ctrl fields
`define SLSC_CTRL_MODE_LSB 0
`define SLSC_CTRL_DSR_FN_LSB 2
`define SLSC_CTRL_DTR_FN_LSB 4
`define SLSC_CTRL_BONDED_BIT 6
`define SLSC_CTRL_GAP_BIT 7
`define SLSC_CTRL_RESET 8'h00
// mode codes
`define SLSC_MODE_CMD 2'h0
`define SLSC_MODE_DATA 2'h1
`define SLSC_MODE_FRAMED 2'h2
// dsr function codes
`define SLSC_DSR_CMD 2'h0
`define SLSC_DSR_DISC 2'h1
`define SLSC_DSR_UART_EN 2'h2
`define SLSC_DSR_SLEEP 2'h3
// dtr function codes
`define SLSC_DTR_MODE 2'h0
`define SLSC_DTR_PEER 2'h1
`define SLSC_DTR_BONDED 2'h2
`define SLSC_DTR_GAP 2'h3
// event bits (write 1 to clear)
`define SLSC_EV_UART_DEFAULTS 0
`define SLSC_EV_CONNECT_REQ 1
`define SLSC_EV_FACTORY 2
`define SLSC_EV_DSR 3
// timing
`define SLSC_CLK_HZ 125000000
`define SLSC_FACTORY_HOLD_S 10
`define SLSC_FLASH_HALF_NS 100000000
`define SLSC_FLASH_HALF_CYC (`SLSC_FLASH_HALF_NS / 8)
`define SLSC_DEBOUNCE_CYC 16
`endif

// File: testbench/slsc_status_ctrl_properties.sv
`timescale 1ns/10ps
module slsc_chk (
	// clock, reset, stimulus
	input wire i_clk,
	input wire i_rstn,
	input wire i_emu_connecting,
	input wire i_emu_connected,
	input wire i_emu_activity,
	input wire i_switch1_n,
	input wire i_switch2_n,
	// watched outputs
	input wire o_red_n,
	input wire o_green_n,
	input wire o_blue_n,
	input wire o_bootloader,
	input wire o_uart_defaults,
	input wire o_factory_restore,
	input wire o_connect_req,
	input wire o_dtr,
	input wire o_uart_enable
);
	reg [4:0] cyc_reg;
	reg ok_reg;
	wire run = cyc_reg == 5'h1f && !o_bootloader;
	wire [2:0] led = {o_red_n, o_green_n, o_blue_n};
	// one cycle of margin after entering run, leds lag by one
	always @(posedge i_clk) begin
		cyc_reg <= !i_rstn ? 5'h00 : cyc_reg + {4'h0, cyc_reg != 5'h1f};
		ok_reg <= i_rstn && run;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	AST_LED_RESET: assert property (disable iff (1'b0) !i_rstn |=> led == 3'h7 && !o_dtr && o_uart_enable)
		else $error("bad reset");
	AST_LED_START: assert property (cyc_reg < 5'h10 |-> led == 3'h7) else $error("led early");
	AST_IDLE: assert property (ok_reg && run && !i_emu_connected && !i_emu_connecting |=> led == 3'h1 || led == 3'h5)
		else $error("idle colour");
	AST_BLUE: assert property (ok_reg && run && i_emu_connected && !i_emu_activity |=> led == 3'h6)
		else $error("not blue");
	AST_PURPLE: assert property (ok_reg && run && i_emu_connecting && !i_emu_connected |=> led == 3'h2)
		else $error("not purple");
	AST_FLASH: assert property (ok_reg && led == 3'h7 |-> $past(i_emu_connected && i_emu_activity))
		else $error("bad flash");
	AST_CONN_REQ: assert property (ok_reg && run && $fell(i_switch2_n) && i_switch1_n |-> ##[1:6] o_connect_req)
		else $error("no connect");
	AST_BOOT: assert property ($rose(o_bootloader) |-> cyc_reg < 5'h1a && $past(!i_switch1_n && !i_switch2_n, 4))
		else $error("bad boot");
	AST_FACTORY: assert property (o_factory_restore |-> $past(o_bootloader) ##1 !o_bootloader)
		else $error("bad factory");
	AST_DEFAULTS: assert property (o_uart_defaults |-> i_switch1_n && cyc_reg < 5'h1a)
		else $error("bad defaults");
endmodule // slsc_chk
bind slsc_status_ctrl slsc_chk chk (.i_clk, .i_rstn, .i_emu_connecting, .i_emu_connected, .i_emu_activity,
	.i_switch1_n, .i_switch2_n, .o_red_n, .o_green_n, .o_blue_n, .o_bootloader, .o_uart_defaults,
	.o_factory_restore, .o_connect_req, .o_dtr, .o_uart_enable);

// File: testbench/slsc_far_side.sv
`timescale 1ns/10ps
module slsc_far_side (
	// bench requests
	input wire i_clk,
	input wire i_press1,
	input wire i_press2,
	input wire i_dsr_req,
	input wire [10:0] i_ext,
	// block pins
	input wire [10:0] i_io_drv,
	input wire [10:0] i_io_oe,
	input wire [10:0] i_io_pu,
	input wire [10:0] i_io_pd,
	output reg o_switch1_n = 1'b1,
	output reg o_switch2_n = 1'b1,
	output reg o_dsr = 1'b0,
	output wire [10:0] o_io
);
	// a press pulls the line low and holds it for the whole press
	always @(posedge i_clk) begin
		o_switch1_n <= !i_press1;
		o_switch2_n <= !i_press2;
		o_dsr <= i_dsr_req;
	end
	// driver wins, then the pull, else the outside world
	assign o_io = (i_io_oe & i_io_drv) | (~i_io_oe & (i_io_pu | (~i_io_pd & i_ext)));
endmodule // slsc_far_side

// File: testbench/test_slsc_status_ctrl.sv
`timescale 1ns/10ps
`include "slsc_regs.vh"
module test_slsc_status_ctrl;
	reg i_clk = 1'b0;
	reg i_rstn = 1'b0;
	reg [3:0] i_addr = 4'h0;
	reg [15:0] i_wdata = 16'h0000;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg i_emu_connecting = 1'b0;
	reg i_emu_connected = 1'b0;
	reg i_emu_activity = 1'b0;
	reg p1 = 1'b0;
	reg p2 = 1'b0;
	reg dsr_req = 1'b0;
	reg [10:0] ext = 11'h000;
	reg [1:0] kind = 2'h0;
	reg look = 1'b0;
	reg rd_d = 1'b0;
	reg [15:0] v;
	reg [15:0] exp_q[$];
	integer n_fail = 0;
	integer checks_done = 0;
	integer seed = 23;
	integer i;
	integer n_cmd = 0, n_disc = 0, n_conn = 0, n_fac = 0, n_def = 0;
	wire [15:0] o_rdata;
	wire i_switch1_n, i_switch2_n, i_dsr, o_dtr, o_red_n, o_green_n, o_blue_n, o_bootloader, o_uart_defaults;
	wire o_factory_restore, o_connect_req, o_dsr_cmd_mode, o_dsr_disconnect, o_uart_enable, o_sleep;
	wire [10:0] i_io, o_io, o_io_oe, o_io_pu, o_io_pd;
	always #4 i_clk = !i_clk;
	slsc_status_ctrl #(.FACTORY_HOLD_CYC(32'd100), .FLASH_HALF_CYC(32'd8)) dut (.i_clk, .i_rstn, .i_addr,
		.i_wdata, .i_wr, .i_rd, .o_rdata, .i_emu_connecting, .i_emu_connected, .i_emu_activity, .i_switch1_n,
		.i_switch2_n, .i_dsr, .o_dtr, .o_red_n, .o_green_n, .o_blue_n, .o_bootloader, .o_uart_defaults,
		.o_factory_restore, .o_connect_req, .o_dsr_cmd_mode, .o_dsr_disconnect, .o_uart_enable, .o_sleep,
		.i_io, .o_io, .o_io_oe, .o_io_pu, .o_io_pd);
	slsc_far_side far (.i_clk, .i_press1(p1), .i_press2(p2), .i_dsr_req(dsr_req), .i_ext(ext), .i_io_drv(o_io),
		.i_io_oe(o_io_oe), .i_io_pu(o_io_pu), .i_io_pd(o_io_pd), .o_switch1_n(i_switch1_n),
		.o_switch2_n(i_switch2_n), .o_dsr(i_dsr), .o_io(i_io));
	task check(input [15:0] seen, input [15:0] want);
	begin
		checks_done = checks_done + 1;
		if (seen !== want) begin
			n_fail = n_fail + 1;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task give_verdict;
	begin
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	end
	endtask
	// kind 0 reads a register, 1 looks at the leds, 2 at uart enable, sleep, bootloader, 3 at dtr
	task req(input [1:0] k, input [3:0] a, input [15:0] e);
	begin
		exp_q.push_back(e);
		@(posedge i_clk);
		kind <= k;
		i_addr <= a;
		i_rd <= k == 2'h0;
		look <= k != 2'h0;
		@(posedge i_clk);
		i_rd <= 1'b0;
		look <= 1'b0;
	end
	endtask
	task restart(input a, input b);
	begin
		@(posedge i_clk);
		i_rstn <= 1'b0;
		p1 <= a;
		p2 <= b;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (30) @(posedge i_clk);
	end
	endtask
	always @(posedge i_clk)
		rd_d <= i_rd;
	// one-cycle pulses are counted where they have settled
	always @(negedge i_clk) begin
		n_cmd = n_cmd + o_dsr_cmd_mode;
		n_disc = n_disc + o_dsr_disconnect;
		n_conn = n_conn + o_connect_req;
		n_fac = n_fac + o_factory_restore;
		n_def = n_def + o_uart_defaults;
	end
	always @(negedge i_clk)
		if (rd_d || look)
			check(kind == 2'h0 ? o_rdata : kind == 2'h1 ? {13'h0, o_red_n, o_green_n, o_blue_n} : kind == 2'h2 ?
				{13'h0, o_uart_enable, o_sleep, o_bootloader} : {15'h0, o_dtr}, exp_q.pop_front());
	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail = n_fail + 1;
		give_verdict;
	end
	initial begin
		restart(1'b0, 1'b0);
		req(0, `SLSC_ADDR_CTRL, 16'h0000);
		req(0, `SLSC_ADDR_IO_DIR, 16'h0000);
		req(0, 4'hf, 16'h0000);
		req(1, 4'h0, 16'h0001);
		for (i = 1; i < 3; i = i + 1) begin
			wr(`SLSC_ADDR_CTRL, i[15:0]);
			req(0, `SLSC_ADDR_CTRL, i[15:0]);
			req(1, 4'h0, 16'h0005);
		end
		i_emu_activity <= 1'b1;
		req(1, 4'h0, 16'h0005);
		i_emu_connecting <= 1'b1;
		req(1, 4'h0, 16'h0002);
		i_emu_connected <= 1'b1;
		for (i = 0; i < 20 && {o_red_n, o_green_n, o_blue_n} !== 3'h7; i = i + 1)
			@(negedge i_clk);
		req(1, 4'h0, 16'h0007);
		i_emu_activity <= 1'b0;
		req(1, 4'h0, 16'h0006);
		i_emu_connected <= 1'b0;
		i_emu_connecting <= 1'b0;
		p2 <= 1'b1;
		repeat (8) @(posedge i_clk);
		p2 <= 1'b0;
		req(0, `SLSC_ADDR_EVENT, 16'h0002);
		check(n_conn[15:0], 16'h0001);
		wr(`SLSC_ADDR_EVENT, 16'h0002);
		wr(`SLSC_ADDR_CTRL, 16'h0008);
		req(2, 4'h0, 16'h0000);
		dsr_req <= 1'b1;
		repeat (5) @(posedge i_clk);
		req(2, 4'h0, 16'h0004);
		req(0, `SLSC_ADDR_EVENT, 16'h0008);
		// dsr must be low again before the next rise and before any later reset
		dsr_req <= 1'b0;
		for (i = 0; i < 3; i = i + 1) begin
			wr(`SLSC_ADDR_CTRL, {12'h000, i[1], i[1] | i[0], 2'h0});
			dsr_req <= 1'b1;
			repeat (5) @(posedge i_clk);
			req(2, 4'h0, {13'h0, 1'b1, i == 2, 1'b0});
			dsr_req <= 1'b0;
		end
		check(n_cmd[15:0], 16'h0001);
		check(n_disc[15:0], 16'h0001);
		for (i = 0; i < 4; i = i + 1) begin
			v = (i[1] ? 16'h0030 : 16'h0020) | (i[0] ? (i[1] ? 16'h0080 : 16'h0040) : 16'h0000);
			wr(`SLSC_ADDR_CTRL, v);
			req(3, 4'h0, {15'h0, i[0]});
		end
		wr(`SLSC_ADDR_CTRL, 16'h0001);
		req(3, 4'h0, 16'h0001);
		wr(`SLSC_ADDR_CTRL, 16'h0010);
		i_emu_connected <= 1'b1;
		req(3, 4'h0, 16'h0001);
		i_emu_connected <= 1'b0;
		v = $random(seed);
		wr(`SLSC_ADDR_IO_DIR, 16'h07ff);
		wr(`SLSC_ADDR_IO_OUT, {5'h00, v[10:0]});
		repeat (3) @(posedge i_clk);
		req(0, `SLSC_ADDR_IO_IN, {5'h00, v[10:0]});
		v = $random(seed);
		wr(`SLSC_ADDR_IO_DIR, 16'h0000);
		wr(`SLSC_ADDR_IO_PULL_EN, 16'h07ff);
		wr(`SLSC_ADDR_IO_PULL_UP, {5'h00, v[10:0]});
		repeat (3) @(posedge i_clk);
		req(0, `SLSC_ADDR_IO_IN, {5'h00, v[10:0]});
		ext <= v[15:5];
		wr(`SLSC_ADDR_IO_PULL_EN, 16'h0000);
		repeat (3) @(posedge i_clk);
		req(0, `SLSC_ADDR_IO_IN, {5'h00, v[15:5]});
		restart(1'b1, 1'b1);
		req(2, 4'h0, 16'h0005);
		repeat (110) @(posedge i_clk);
		req(2, 4'h0, 16'h0004);
		req(0, `SLSC_ADDR_EVENT, 16'h0004);
		req(1, 4'h0, 16'h0001);
		restart(1'b1, 1'b1);
		p1 <= 1'b0;
		repeat (120) @(posedge i_clk);
		req(2, 4'h0, 16'h0005);
		req(0, `SLSC_ADDR_EVENT, 16'h0000);
		req(0, `SLSC_ADDR_STATUS, 16'h0048);
		restart(1'b0, 1'b1);
		req(0, `SLSC_ADDR_EVENT, 16'h0001);
		req(2, 4'h0, 16'h0004);
		req(0, `SLSC_ADDR_STATUS, 16'h0080);
		check(n_fac[15:0], 16'h0001);
		check(n_def[15:0], 16'h0001);
		give_verdict;
	end
endmodule // test_slsc_status_ctrl
